// File: bench/cpu_mode_stack_page_ctrl_test.sv
`timescale 1ns/1ps
`include "smsc_cfg.svh"
module cpu_mode_stack_page_ctrl_test;
  logic mclk = 0;
  logic sys_rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic slv_err;
  logic [23:0] stack_base;
  logic [7:0] v;
  logic [7:0] b;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  smsc_if bus();
  smsc_dev u_smsc_dev(.mclk, .sys_rst, .bus(bus), .stack_base);
  smsc_cpu u_smsc_cpu(.mclk, .sys_rst, .bus(bus), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  smsc_properties u_props(.mclk, .sys_rst, .io_addr(bus.io_addr), .io_wr(bus.io_wr), .io_rd(bus.io_rd),
    .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata), .inst_end(bus.inst_end), .call_push_cb(bus.call_push_cb),
    .irq_block(bus.irq_block), .stack_page(bus.stack_page));
  initial forever #12.5 mclk = ~mclk;
  task automatic wrap_up;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // first push lands just below this, as the stack pointer is pre-decremented
  function automatic logic [23:0] top_of(logic [7:0] pg);
    return {pg, 16'hF800};
  endfunction : top_of
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // one device access, then poll busy so the next order is never dropped
  task automatic io(logic w, logic [23:0] a, logic [7:0] d);
    apb(1, `SMSC_HOST_WDATA, {24'h00_0000, d});
    apb(1, `SMSC_HOST_CTRL, {a, 6'h00, w, 1'b1});
    do apb(0, `SMSC_HOST_STAT, 0); while (rd[0] !== 1'b0);
    apb(0, `SMSC_HOST_RDATA, 0);
  endtask : io
  initial begin
    void'($urandom(75567));
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    for (int r = 0; r < 2; r++) begin
      // second round writes page zero back: the value must not matter for release
      v = r ? 8'h00 : 8'($urandom);
      b = 8'(2 + $urandom % 6);
      apb(0, `SMSC_HOST_STAT, 0);
      chk("reset", {rd[19:12], rd[2:1]}, 10'h001);
      apb(0, `SMSC_HOST_CB, 0);
      chk("bank_rst", rd[7:0], `SMSC_CB_RST);
      apb(1, `SMSC_HOST_CB, {24'h00_0000, b});
      apb(0, `SMSC_HOST_CB, 0);
      chk("bank", rd[7:0], b);
      io(1, `SMSC_MODE_ADDR, v | 8'h40);
      io(0, `SMSC_MODE_ADDR, 0);
      chk("mode", rd[7:0], 8'h40);
      apb(0, `SMSC_HOST_STAT, 0);
      chk("half", rd[2:1], 2'b11);
      io(1, `SMSC_PAGE_ADDR, v);
      io(0, `SMSC_PAGE_ADDR, 0);
      chk("page", rd[7:0], v);
      chk("base", stack_base, {v, 16'h0000});
      chk("top", stack_base + 24'h00_F800, top_of(v));
      io(1, `SMSC_MODE_ADDR, v & 8'hBF);
      apb(0, `SMSC_HOST_STAT, 0);
      chk("free", {rd[19:12], rd[2:1]}, {v, 2'b00});
      apb(0, 12'h0FC, 0);
      chk("unmap_err", slv_err, 1'b1);
      chk("unmap_rd", rd, 32'h0000_0000);
      // leave maximum mode set so the reset that follows has something to clear
      io(1, `SMSC_MODE_ADDR, 8'hFF);
      sys_rst <= 1;
      repeat (2) @(posedge mclk);
      sys_rst <= 0;
    end
    wrap_up();
  end
endmodule : cpu_mode_stack_page_ctrl_test

// File: bench/smsc_properties.sv
`timescale 1ns/1ps
`include "smsc_cfg.svh"
module smsc_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [23:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic inst_end,
  input wire logic call_push_cb,
  input wire logic irq_block,
  input wire logic [7:0] stack_page
);
  wire logic wm = io_wr && io_addr == `SMSC_MODE_ADDR;
  wire logic wp = io_wr && io_addr == `SMSC_PAGE_ADDR;
  logic sm_q;
  logic sp_q;
  // release needs both writes seen since reset, whatever the values
  always_ff @(posedge mclk) sm_q <= !sys_rst && (sm_q || wm);
  always_ff @(posedge mclk) sp_q <= !sys_rst && (sp_q || wp);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence page_wr_s;
    wp;
  endsequence
  a_mode_write: assert property (wm |=> call_push_cb == $past(io_wdata[6]))
    else $error("mode bit not taken");
  a_mode_keep: assert property (!wm |=> $stable(call_push_cb))
    else $error("mode changed without write");
  a_page_write: assert property (wp |=> stack_page == $past(io_wdata))
    else $error("page not taken");
  a_mode_read: assert property (io_rd && io_addr == `SMSC_MODE_ADDR |=> io_rdata == {1'b0, call_push_cb, 6'h00})
    else $error("mode readback wrong");
  a_init_block: assert property (!(sm_q && sp_q) |-> irq_block)
    else $error("released before both writes");
  a_page_hold: assert property (page_wr_s |=> irq_block)
    else $error("no hold after page write");
  a_hold_release: assert property (sm_q && sp_q && inst_end && !wp |=> !irq_block)
    else $error("block not released");
  a_reset_vals: assert property (disable iff (1'b0) sys_rst |=> !call_push_cb && stack_page == 8'h00 && irq_block)
    else $error("reset values wrong");
endmodule : smsc_properties

// File: common/smsc_cfg.svh
`ifndef SMSC_CFG_SVH
`define SMSC_CFG_SVH
`define SMSC_MODE_ADDR 24'h00_FF00
`define SMSC_PAGE_ADDR 24'h00_FF01
`define SMSC_MODE_BIT 6
`define SMSC_MODE_RST 1'b0
`define SMSC_PAGE_RST 8'h00
`define SMSC_PAGE_BYTES 24'h01_0000
`define SMSC_HOST_CTRL 12'h000
`define SMSC_HOST_WDATA 12'h004
`define SMSC_HOST_STAT 12'h008
`define SMSC_HOST_RDATA 12'h00C
`define SMSC_HOST_CB 12'h010
`define SMSC_CB_RST 8'h01
`endif

// File: common/smsc_if.sv
`timescale 1ns/1ps
interface smsc_if;
  logic [23:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic inst_end;
  logic call_push_cb;
  logic irq_block;
  logic [7:0] stack_page;
  modport dev (input io_addr, io_wr, io_rd, io_wdata, inst_end,
               output io_rdata, call_push_cb, irq_block, stack_page);
  modport cpu (output io_addr, io_wr, io_rd, io_wdata, inst_end,
               input io_rdata, call_push_cb, irq_block, stack_page);
endinterface : smsc_if

// File: common/smsc_pkg.sv
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_IDLE = 3'b001,
    SMSC_REQ = 3'b010,
    SMSC_DONE = 3'b100
  } smsc_state_e;
  typedef logic [7:0] smsc_byte_t;
endpackage : smsc_pkg

// File: logic/smsc_cpu.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "smsc_cfg.svh"
// cpu-side stand-in: takes byte i/o orders over apb and drives the device end
module smsc_cpu
  import smsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  smsc_if.cpu bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  smsc_state_e state_q;
  logic [23:0] addr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] cb_q;
  logic [31:0] prdata_q;
  logic acc;
  logic busy;
  logic mapped;

  assign acc = psel && penable;
  assign busy = state_q != SMSC_IDLE;
  assign mapped = paddr inside {`SMSC_HOST_CTRL, `SMSC_HOST_WDATA, `SMSC_HOST_STAT,
                                `SMSC_HOST_RDATA, `SMSC_HOST_CB};

  // ctrl: bit0 go, bit1 write, bits 31:8 io address; cb bank is chosen by software
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_q <= 24'h00_0000;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      cb_q <= `SMSC_CB_RST;
    end else if (acc && pwrite) begin
      if (paddr == `SMSC_HOST_CTRL && !busy) begin
        addr_q <= pwdata[31:8];
        wr_q <= pwdata[1];
      end
      if (paddr == `SMSC_HOST_WDATA) begin
        wdata_q <= pwdata[7:0];
      end
      if (paddr == `SMSC_HOST_CB) begin
        cb_q <= pwdata[7:0];
      end
    end
  end

  // one access cycle, then one instruction-end cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= SMSC_IDLE;
    end else begin
      unique case (state_q)
        SMSC_IDLE: begin
          if (acc && pwrite && paddr == `SMSC_HOST_CTRL && pwdata[0]) begin
            state_q <= SMSC_REQ;
          end
        end
        SMSC_REQ: state_q <= SMSC_DONE;
        SMSC_DONE: state_q <= SMSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (state_q == SMSC_DONE && !wr_q) begin
      rdata_q <= bus.io_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `SMSC_HOST_CTRL: prdata_q <= {addr_q, 6'h00, wr_q, 1'b0};
        `SMSC_HOST_WDATA: prdata_q <= {24'h00_0000, wdata_q};
        `SMSC_HOST_STAT: prdata_q <= {12'h000, bus.stack_page, 9'h000, bus.call_push_cb, bus.irq_block, busy};
        `SMSC_HOST_RDATA: prdata_q <= {24'h00_0000, rdata_q};
        `SMSC_HOST_CB: prdata_q <= {24'h00_0000, cb_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign bus.io_addr = addr_q;
  assign bus.io_wr = state_q == SMSC_REQ && wr_q;
  assign bus.io_rd = state_q == SMSC_REQ && !wr_q;
  assign bus.io_wdata = wdata_q;
  assign bus.inst_end = state_q == SMSC_DONE;
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
endmodule : smsc_cpu

// File: logic/smsc_dev.sv
`timescale 1ns/1ps
`include "smsc_cfg.svh"
// How it works
// - mode bit one is maximum, zero minimum
// - mode bit clears to minimum at reset
// - minimum mode: code bank not pushed
// - maximum mode: code bank pushed on call
// - software picks mode by program size
// - minimum, lower ROM only: bank one
// - minimum, second ROM area: bank two-seven
// - maximum: rewrite code bank on switch
// - eight-bit stack page register, resets zero
// - page is one 64K data division
// - software sets stack pointer F800H
// - interrupts blocked until both registers written
// - stack page write blocks one instruction
// - software writes both registers at init
module smsc_dev
  import smsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  smsc_if.dev bus,
  output logic [23:0] stack_base
);
  logic mode_q;
  smsc_byte_t page_q;
  logic mode_seen_q;
  logic page_seen_q;
  logic hold_q;
  logic [7:0] rdata_q;
  logic hit_mode;
  logic hit_page;

  assign hit_mode = bus.io_addr == `SMSC_MODE_ADDR;
  assign hit_page = bus.io_addr == `SMSC_PAGE_ADDR;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= `SMSC_MODE_RST;
    end else if (bus.io_wr && hit_mode) begin
      mode_q <= bus.io_wdata[`SMSC_MODE_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      page_q <= `SMSC_PAGE_RST;
    end else if (bus.io_wr && hit_page) begin
      page_q <= bus.io_wdata;
    end
  end

  // release flags stick until reset, whatever value was written
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_seen_q <= 1'b0;
      page_seen_q <= 1'b0;
    end else begin
      if (bus.io_wr && hit_mode) begin
        mode_seen_q <= 1'b1;
      end
      if (bus.io_wr && hit_page) begin
        page_seen_q <= 1'b1;
      end
    end
  end

  // hold runs from the page write until the next instruction end; a new write wins over the end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_q <= 1'b0;
    end else if (bus.io_wr && hit_page) begin
      hold_q <= 1'b1;
    end else if (bus.inst_end) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (bus.io_rd) begin
      if (hit_mode) begin
        rdata_q <= {1'b0, mode_q, 6'h00};
      end else if (hit_page) begin
        rdata_q <= page_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign bus.io_rdata = rdata_q;
  assign bus.call_push_cb = mode_q;
  assign bus.irq_block = !(mode_seen_q && page_seen_q) || hold_q;
  assign bus.stack_page = page_q;
  assign stack_base = {page_q, 16'h0000};
endmodule : smsc_dev
